// file: core/pdc_config_decode.sv
// Clock generator configuration image and PLL / post divider decode.
`timescale 1ns/1ps

// Contract
// RL1 - Four 8-bit reference divider fields sit at bits 7-0, 31-24, 55-48 and 79-72.
// RL2 - Path select low uses the first C/D set, high uses the second set.
// RL3 - Each 11-bit feedback field splits into low count bits 2:0 and high count bits 10:3.
// RL4 - Post divider fields sit at 99-96, 103-100, 107-104, 111-108, 115-112 and 119-116.
// RL5 - Post codes 0 to 15 map to ratios 1,2,3,4,5,6,8,9,10,12,15,16,18,20,25,50.
// RL6 - A clear filter bit means 7 us, a set bit 20 us, at bits 20, 44, 68 and 92.
// RL7 - A clear pump bit means 2 uA, a set bit 10 uA, at bits 19, 43, 67 and 91.
// RL8 - Every configuration bit is zero after reset.
// RL9 - Active C and D settings follow the selected set and switch with the select input.
module pdc_config_decode
    import pdc_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    // Register port
    input  wire logic [ADDR_W-1:0]     regAddr,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regWrStrobe,
    input  wire logic                  regRdStrobe,
    output logic      [7:0]            regRdData,
    // Board select for the C and D paths
    input  wire logic                  pathSetSelect,
    // PLL A settings
    output logic      [REF_W-1:0]      refDivPathA,
    output logic      [FB_LOW_W-1:0]   fbLowPathA,
    output logic      [FB_HIGH_W-1:0]  fbHighPathA,
    output logic      [TC_W-1:0]       filterTcPathA,
    output logic      [CP_W-1:0]       pumpCurrentPathA,
    // PLL B settings
    output logic      [REF_W-1:0]      refDivPathB,
    output logic      [FB_LOW_W-1:0]   fbLowPathB,
    output logic      [FB_HIGH_W-1:0]  fbHighPathB,
    output logic      [TC_W-1:0]       filterTcPathB,
    output logic      [CP_W-1:0]       pumpCurrentPathB,
    // PLL C settings, from the selected set
    output logic      [REF_W-1:0]      refDivPathC,
    output logic      [FB_LOW_W-1:0]   fbLowPathC,
    output logic      [FB_HIGH_W-1:0]  fbHighPathC,
    output logic      [TC_W-1:0]       filterTcPathC,
    output logic      [CP_W-1:0]       pumpCurrentPathC,
    // Post divider ratios
    output logic      [RATIO_W-1:0]    outDivPathA,
    output logic      [RATIO_W-1:0]    outDivPathB,
    output logic      [RATIO_W-1:0]    outDivPathC,
    output logic      [RATIO_W-1:0]    outDivPathD
);

    // ------------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------------
    logic [CFG_BITS-1:0] cfgImage;

    // Storage clears to zero at reset. [RL8]
    pdc_config_store #(
        .BYTES (CFG_BYTES),
        .AW    (ADDR_W)
    ) u_store (
        .core_clk (core_clk),
        .reset    (reset),
        .addr     (regAddr),
        .wrData   (regWrData),
        .wrStrobe (regWrStrobe),
        .rdStrobe (regRdStrobe),
        .rdData   (regRdData),
        .image    (cfgImage)
    );

    // ------------------------------------------------------------------
    // PLL setting decode
    // ------------------------------------------------------------------
    logic [REF_W-1:0]     refDiv_ff   [NUM_PLL];
    logic [FB_LOW_W-1:0]  fbLow_ff    [NUM_PLL];
    logic [FB_HIGH_W-1:0] fbHigh_ff   [NUM_PLL];
    logic [TC_W-1:0]      filterTc_ff [NUM_PLL];
    logic [CP_W-1:0]      pump_ff     [NUM_PLL];

    // Decoding is registered so every output comes from a flop; the
    // cost is one cycle of latency after a write or a select change.
    for (genvar p = 0; p < NUM_PLL; p++) begin : g_pll
        localparam int ALT = (p == 2) ? 3 : p;
        logic              useAlt;
        logic [REF_W-1:0]  nxt_refDiv;
        logic [FB_W-1:0]   nxt_fb;
        logic              tcBit;
        logic              cpBit;

        assign useAlt = (p == 2) && pathSetSelect; // [RL2] [RL9]
        assign nxt_refDiv = useAlt ? cfgImage[REF_LSB[ALT] +: REF_W]
                                   : cfgImage[REF_LSB[p] +: REF_W]; // [RL1]
        assign nxt_fb = useAlt ? cfgImage[FB_LSB[ALT] +: FB_W]
                               : cfgImage[FB_LSB[p] +: FB_W];
        assign tcBit = useAlt ? cfgImage[TC_BIT[ALT]] : cfgImage[TC_BIT[p]];
        assign cpBit = useAlt ? cfgImage[CP_BIT[ALT]] : cfgImage[CP_BIT[p]];

        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                refDiv_ff[p]   <= REF_RESET;
                fbLow_ff[p]    <= FBL_RESET;
                fbHigh_ff[p]   <= FBH_RESET;
                filterTc_ff[p] <= TC_SHORT_US;
                pump_ff[p]     <= CP_LOW_UA;
            end else begin
                refDiv_ff[p]   <= nxt_refDiv;
                fbLow_ff[p]    <= nxt_fb[FB_LOW_W-1:0];          // [RL3]
                fbHigh_ff[p]   <= nxt_fb[FB_W-1:FB_LOW_W];       // [RL3]
                filterTc_ff[p] <= tcBit ? TC_LONG_US : TC_SHORT_US; // [RL6]
                pump_ff[p]     <= cpBit ? CP_HIGH_UA : CP_LOW_UA;   // [RL7]
            end
        end
    end

    // ------------------------------------------------------------------
    // Post divider decode
    // ------------------------------------------------------------------
    logic [RATIO_W-1:0] ratio_ff [NUM_POST];

    // C and D each have two codes; A and B have one.
    for (genvar q = 0; q < NUM_POST; q++) begin : g_post
        localparam int ALT = (q < 2) ? q : q + 2;
        logic              useAlt;
        logic [POST_W-1:0] nxt_code;

        assign useAlt = (q >= 2) && pathSetSelect; // [RL2] [RL9]
        assign nxt_code = useAlt ? cfgImage[POST_LSB[ALT] +: POST_W]
                                 : cfgImage[POST_LSB[q] +: POST_W]; // [RL4]

        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                ratio_ff[q] <= RATIO_RESET;
            end else begin
                ratio_ff[q] <= post_ratio(nxt_code); // [RL5]
            end
        end
    end

    // ------------------------------------------------------------------
    // Output wiring
    // ------------------------------------------------------------------
    assign refDivPathA      = refDiv_ff[0];
    assign fbLowPathA       = fbLow_ff[0];
    assign fbHighPathA      = fbHigh_ff[0];
    assign filterTcPathA    = filterTc_ff[0];
    assign pumpCurrentPathA = pump_ff[0];
    assign refDivPathB      = refDiv_ff[1];
    assign fbLowPathB       = fbLow_ff[1];
    assign fbHighPathB      = fbHigh_ff[1];
    assign filterTcPathB    = filterTc_ff[1];
    assign pumpCurrentPathB = pump_ff[1];
    assign refDivPathC      = refDiv_ff[2];
    assign fbLowPathC       = fbLow_ff[2];
    assign fbHighPathC      = fbHigh_ff[2];
    assign filterTcPathC    = filterTc_ff[2];
    assign pumpCurrentPathC = pump_ff[2];
    assign outDivPathA      = ratio_ff[0];
    assign outDivPathB      = ratio_ff[1];
    assign outDivPathC      = ratio_ff[2];
    assign outDivPathD      = ratio_ff[3];

endmodule

// file: core/pdc_config_store.sv
// Byte-wide storage for the 128-bit configuration image.
`timescale 1ns/1ps

module pdc_config_store
    import pdc_pkg::*;
#(
    parameter int BYTES = CFG_BYTES,
    parameter int AW    = ADDR_W
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // Access port
    input  wire logic [AW-1:0]     addr,
    input  wire logic [7:0]        wrData,
    input  wire logic              wrStrobe,
    input  wire logic              rdStrobe,
    output logic      [7:0]        rdData,
    // Whole image, straight from the storage flops
    output logic      [BYTES*8-1:0] image
);

    // ------------------------------------------------------------------
    // Storage bytes
    // ------------------------------------------------------------------
    logic [7:0] mem_ff [BYTES];
    logic [7:0] rdData_ff;

    // Each byte clears at reset and takes a write aimed at it.
    for (genvar i = 0; i < BYTES; i++) begin : g_byte
        localparam logic [7:0] MASK = (i == RSVD_BYTE) ? RSVD_MASK : 8'hFF;
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                mem_ff[i] <= CFG_BYTE_RESET;
            end else if (wrStrobe && addr == AW'(i)) begin
                mem_ff[i] <= wrData & MASK;
            end
        end
        assign image[i*8 +: 8] = mem_ff[i];
    end

    // Read data stand for one cycle only; zero otherwise so a stale
    // value cannot be mistaken for an answer.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdData_ff <= CFG_BYTE_RESET;
        end else if (rdStrobe) begin
            rdData_ff <= mem_ff[addr];
        end else begin
            rdData_ff <= CFG_BYTE_RESET;
        end
    end

    assign rdData = rdData_ff;

endmodule

// file: core/pdc_pkg.sv
// Constants, field layout and decode helpers for the clock configuration.
package pdc_pkg;

    // ------------------------------------------------------------------
    // Configuration image geometry
    // ------------------------------------------------------------------
    localparam int CFG_BYTES = 16;
    localparam int CFG_BITS  = 128;
    localparam int ADDR_W    = 4;
    localparam int BYTE_W    = 8;

    // All configuration bits start at zero after reset.
    localparam logic [7:0] CFG_BYTE_RESET = 8'h00;

    // Byte 11 bit 5 is reserved; it always reads and stays zero.
    localparam int         RSVD_BYTE = 11;
    localparam logic [7:0] RSVD_MASK = 8'hDF;

    // ------------------------------------------------------------------
    // Field widths
    // ------------------------------------------------------------------
    localparam int REF_W     = 8;
    localparam int FB_W      = 11;
    localparam int FB_LOW_W  = 3;
    localparam int FB_HIGH_W = 8;
    localparam int POST_W    = 4;
    localparam int RATIO_W   = 6;
    localparam int TC_W      = 5;
    localparam int CP_W      = 4;

    // ------------------------------------------------------------------
    // Field positions, index order: A, B, C set one, C set two
    // ------------------------------------------------------------------
    localparam int NUM_PLL_SRC = 4;
    localparam int NUM_PLL     = 3;
    localparam int REF_LSB [NUM_PLL_SRC] = '{0, 24, 48, 72};
    localparam int FB_LSB  [NUM_PLL_SRC] = '{8, 32, 56, 80};
    localparam int CP_BIT  [NUM_PLL_SRC] = '{19, 43, 67, 91};
    localparam int TC_BIT  [NUM_PLL_SRC] = '{20, 44, 68, 92};

    // Post divider positions, order: A, B, C1, D1, C2, D2.
    localparam int NUM_POST_SRC = 6;
    localparam int NUM_POST     = 4;
    localparam int POST_LSB [NUM_POST_SRC] = '{96, 100, 104, 108, 112, 116};

    // ------------------------------------------------------------------
    // Tuning values in their own units
    // ------------------------------------------------------------------
    localparam logic [TC_W-1:0] TC_SHORT_US = 5'h07;
    localparam logic [TC_W-1:0] TC_LONG_US  = 5'h14;
    localparam logic [CP_W-1:0] CP_LOW_UA   = 4'h2;
    localparam logic [CP_W-1:0] CP_HIGH_UA  = 4'hA;

    // Decoded values that follow from an all-zero image.
    localparam logic [RATIO_W-1:0]   RATIO_RESET = 6'h01;
    localparam logic [REF_W-1:0]     REF_RESET   = 8'h00;
    localparam logic [FB_LOW_W-1:0]  FBL_RESET   = 3'h0;
    localparam logic [FB_HIGH_W-1:0] FBH_RESET   = 8'h00;

    // Post divider code to divide ratio.
    function automatic logic [RATIO_W-1:0] post_ratio(
        input logic [POST_W-1:0] code
    );
        case (code)
            4'h0:    post_ratio = 6'h01;
            4'h1:    post_ratio = 6'h02;
            4'h2:    post_ratio = 6'h03;
            4'h3:    post_ratio = 6'h04;
            4'h4:    post_ratio = 6'h05;
            4'h5:    post_ratio = 6'h06;
            4'h6:    post_ratio = 6'h08;
            4'h7:    post_ratio = 6'h09;
            4'h8:    post_ratio = 6'h0A;
            4'h9:    post_ratio = 6'h0C;
            4'hA:    post_ratio = 6'h0F;
            4'hB:    post_ratio = 6'h10;
            4'hC:    post_ratio = 6'h12;
            4'hD:    post_ratio = 6'h14;
            4'hE:    post_ratio = 6'h19;
            default: post_ratio = 6'h32;
        endcase
    endfunction

endpackage

// file: tb/pdc_config_props.sv
// Concurrent checks on the clock configuration decode ports.
`timescale 1ns/1ps
module pdc_config_props
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               reset,
    // Register port and select
    input wire logic [ADDR_W-1:0]  regAddr,
    input wire logic [7:0]         regWrData,
    input wire logic               regWrStrobe,
    input wire logic               regRdStrobe,
    input wire logic [7:0]         regRdData,
    input wire logic               pathSetSelect,
    // Decoded settings
    input wire logic [REF_W-1:0]   refDivPathA,
    input wire logic [REF_W-1:0]   refDivPathC,
    input wire logic [TC_W-1:0]    filterTcPathB,
    input wire logic [CP_W-1:0]    pumpCurrentPathC,
    input wire logic [RATIO_W-1:0] outDivPathD
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // A write and its read-back follow each other with no gap.
    sequence wrThenRd;
        regWrStrobe ##1 regRdStrobe && regAddr == $past(regAddr);
    endsequence
    // No write and no select change, so nothing may move downstream.
    sequence quiet;
        !regWrStrobe && $stable(pathSetSelect);
    endsequence

    chk_rd_idle: assert property (!regRdStrobe |=> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    chk_rd_after_wr: assert property (wrThenRd |=>
        regRdData == ($past(regWrData, 2) &
        ($past(regAddr, 2) == ADDR_W'(RSVD_BYTE) ? RSVD_MASK : 8'hFF)))
        else $error("read-back differs from write");
    chk_ref_write: assert property (regWrStrobe &&
        regAddr == 4'h0 |=> ##1 refDivPathA == $past(regWrData, 2))
        else $error("reference divider A not from byte zero");
    chk_ref_other: assert property (!(regWrStrobe &&
        regAddr == 4'h0) |=> ##1 $stable(refDivPathA))
        else $error("reference divider A moved without its byte");
    chk_hold_quiet: assert property (quiet ##1 quiet |=>
        $stable(refDivPathC) && $stable(outDivPathD))
        else $error("path C or D moved while quiet");
    // Byte 5 bit 4 is the B filter bit; the decode lags the write by one.
    chk_tc_write: assert property (regWrStrobe &&
        regAddr == 4'h5 |=> ##1 filterTcPathB ==
        ($past(regWrData[4], 2) ? TC_LONG_US : TC_SHORT_US))
        else $error("filter constant B not from its bit");
    // Byte 8 bit 3 is the set one pump bit, used while select is low.
    chk_cp_select: assert property (regWrStrobe &&
        regAddr == 4'h8 ##1 !pathSetSelect |=> pumpCurrentPathC ==
        ($past(regWrData[3], 2) ? CP_HIGH_UA : CP_LOW_UA))
        else $error("pump current C not from set one bit");
    chk_ratio_legal: assert property (outDivPathD inside {1, 2,
        3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18, 20, 25, 50})
        else $error("post ratio outside the table");
endmodule

bind pdc_config_decode pdc_config_props pdc_config_props_i (
    .core_clk, .reset, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe,
    .regRdData, .pathSetSelect, .refDivPathA, .refDivPathC,
    .filterTcPathB, .pumpCurrentPathC, .outDivPathD);

// file: tb/pdc_host_model.sv
// Host that writes and reads configuration bytes over the register port.
`timescale 1ns/1ps
module pdc_host_model (
    // Clock
    input wire logic        core_clk,
    // Register port
    output logic [3:0]      regAddr     = 4'h0,
    output logic [7:0]      regWrData   = 8'h00,
    output logic            regWrStrobe = 1'b0,
    output logic            regRdStrobe = 1'b0,
    input wire logic [7:0]  regRdData
);
    // Write one byte, then read it straight back when asked.
    task automatic xfer(input logic [3:0] a, input logic [7:0] d,
                        input bit rdBack, output logic [7:0] q);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge core_clk);
        regWrStrobe <= 1'b0;
        regWrData <= ~d; // Idle data is scrambled so no stale value helps.
        if (rdBack) begin
            regRdStrobe <= 1'b1;
            @(posedge core_clk);
            regRdStrobe <= 1'b0;
        end
        @(posedge core_clk);
        q = regRdData;
    endtask

    // Plain read; data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge core_clk);
        regRdStrobe <= 1'b0;
        @(posedge core_clk);
        q = regRdData;
    endtask
endmodule

// file: tb/tb_pdc_config_decode.sv
// Self-checking bench for the clock configuration decode.
`timescale 1ns/1ps
module tb_pdc_config_decode import pdc_pkg::*;;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        sel = 1'b0;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData, regRdData, refD [3], fbH [3];
    logic        regWrStrobe, regRdStrobe;
    logic [2:0]  fbL [3];
    logic [4:0]  tc [3];
    logic [3:0]  cp [3];
    logic [5:0]  od [4];
    logic [127:0] img = '0;
    int          bad_count = 0;
    int          comparisons = 0;
    bit [31:0]   rs = 32'h5f90;
    int          rt [16] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 15, 16, 18,
                             20, 25, 50};

    pdc_host_model pdc_host_model_i (.core_clk, .regAddr, .regWrData,
        .regWrStrobe, .regRdStrobe, .regRdData);
    pdc_config_decode pdc_config_decode_i (.core_clk, .reset, .regAddr,
        .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
        .pathSetSelect(sel), .refDivPathA(refD[0]), .fbLowPathA(fbL[0]),
        .fbHighPathA(fbH[0]), .filterTcPathA(tc[0]),
        .pumpCurrentPathA(cp[0]), .refDivPathB(refD[1]),
        .fbLowPathB(fbL[1]), .fbHighPathB(fbH[1]), .filterTcPathB(tc[1]),
        .pumpCurrentPathB(cp[1]), .refDivPathC(refD[2]),
        .fbLowPathC(fbL[2]), .fbHighPathC(fbH[2]), .filterTcPathC(tc[2]),
        .pumpCurrentPathC(cp[2]), .outDivPathA(od[0]), .outDivPathB(od[1]),
        .outDivPathC(od[2]), .outDivPathD(od[3]));

    // Free-running 25 MHz clock.
    initial forever #20 core_clk = ~core_clk;

    function bit [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Field of the model image, widened to an integer.
    function int fld(int lsb, int w);
        return int'((img >> lsb) & ((128'h1 << w) - 1));
    endfunction

    task automatic cmp_out(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %0h seen %0h", n, e, g);
        end
    endtask

    // Read a byte and compare it against the model image.
    task automatic cmp_read(int a);
        logic [7:0] q;
        pdc_host_model_i.rd(a[3:0], q);
        cmp_out("read", img[a*8 +: 8], q);
    endtask

    // Write one byte, keep the model, and check the next-cycle read-back.
    task automatic wr(int a, logic [7:0] d);
        logic [7:0] q;
        img[a*8 +: 8] = d & (a == RSVD_BYTE ? RSVD_MASK : 8'hFF);
        pdc_host_model_i.xfer(a[3:0], d, 1'b1, q);
        cmp_out("readback", img[a*8 +: 8], q);
    endtask

    // Compare every decoded output with the model; C and D follow sel.
    task automatic check_all();
        int s;
        for (int p = 0; p < 3; p++) begin
            s = p < 2 ? p : (sel ? 3 : 2);
            cmp_out("ref", fld(REF_LSB[s], 8), refD[p]);
            cmp_out("fbl", fld(FB_LSB[s], 3), fbL[p]);
            cmp_out("fbh", fld(FB_LSB[s] + 3, 8), fbH[p]);
            cmp_out("tc", fld(TC_BIT[s], 1) ? 20 : 7, tc[p]);
            cmp_out("cp", fld(CP_BIT[s], 1) ? 10 : 2, cp[p]);
        end
        for (int p = 0; p < 4; p++) begin
            s = p < 2 ? p : p + (sel ? 2 : 0);
            cmp_out("div", rt[fld(POST_LSB[s], 4)], od[p]);
        end
    endtask

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hang counts as a mismatch and still reaches the report.
    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        close_out();
    end

    // Reset, random images under both selects, then every post code.
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check_all();
        for (int a = 0; a < 16; a++) cmp_read(a);
        for (int i = 0; i < 24; i++) begin
            for (int a = 0; a < 16; a++) wr(a, xs() & 8'hFF);
            sel <= 1'(xs() & 32'h1);
            repeat (2) @(posedge core_clk);
            check_all();
            sel <= ~sel;
            repeat (2) @(posedge core_clk);
            check_all();
            cmp_read(i % 16);
        end
        // Reset again mid-run; every field must fall back to code zero.
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        img = '0;
        @(posedge core_clk);
        check_all();
        cmp_read(5);
        // Every post code on every divider, under both selects.
        for (int c = 0; c < 16; c++) begin
            wr(12, {c[3:0], c[3:0]});
            wr(13, {c[3:0], c[3:0]});
            wr(14, {c[3:0], c[3:0]});
            repeat (2) @(posedge core_clk);
            check_all();
            sel <= ~sel;
            repeat (2) @(posedge core_clk);
            check_all();
        end
        close_out();
    end
endmodule
